// [core/ssdp_top.sv]
// Purpose: asynchronous serial data port with flow control and control outputs
// Assumes: config ports are static while I_CFG_LOAD pulses
// Notes:   receive path holds a two-entry buffer
`timescale 1ns/10ps
`include "ssdp_params.svh"
module ssdp_top (
	// clock and reset
	input  wire logic       I_CLK,
	input  wire logic       I_NRST,
	// configuration, taken on I_CFG_LOAD
	input  wire logic       I_CFG_LOAD,
	input  wire logic [2:0] I_BAUD_SEL,
	input  wire logic [1:0] I_PARITY_SEL,
	input  wire logic       I_TWO_STOP,
	input  wire logic       I_FOUR_WIRE,
	input  wire logic       I_RS485,
	input  wire logic       I_BINARY_MODE,
	input  wire logic [4:0] I_NET_ADDR,
	input  wire logic       I_SHORT_LINE,
	input  wire logic [7:0] I_AUTO_INTERVAL,
	// transmit stream
	input  wire logic [7:0] I_TX_DATA,
	input  wire logic       I_TX_VALID,
	output logic            O_TX_READY,
	// receive stream
	output logic [7:0]      O_RX_DATA,
	output logic            O_RX_PERR,
	output logic            O_RX_FERR,
	output logic            O_RX_VALID,
	input  wire logic       I_RX_READY,
	output logic            O_RX_OVERRUN,
	output logic            O_ADDR_MATCH,
	// serial pins
	input  wire logic       I_RXD,
	output logic            O_TXD,
	output logic            O_TXD_OE,
	input  wire logic       I_CTS,
	output logic            O_DTR,
	// display timing and format
	input  wire logic       I_DISP_UPDATE,
	output logic            O_AUTO_TRIG,
	output logic [4:0]      O_LINE_LEN,
	// checkweighing results and outputs
	input  wire logic       I_CW_SET,
	input  wire logic       I_CW_EQUAL,
	input  wire logic       I_CW_LIGHTER,
	input  wire logic       I_CW_HEAVIER,
	output logic            O_CW_SET,
	output logic            O_CW_EQUAL,
	output logic            O_CW_LIGHTER,
	output logic            O_CW_HEAVIER
);
	// ----------------------------------------------------------------
	// configuration
	// ----------------------------------------------------------------
	logic [2:0]        baud_q;  // rate index
	ssdp_pkg::ssdp_par_t par_q; // parity choice
	logic              stop2_q, fourw_q, rs485_q, bin_q, short_q;
	logic [4:0]        addr_q;  // network address
	logic [7:0]        ivl_q;   // auto output interval
	logic [`SSDP_DIV_W-1:0] div;  // bit period in clocks
	logic [3:0]        nbits;   // data bits per frame
	ssdp_pkg::ssdp_par_t epar;  // effective parity
	logic              estop2;  // effective two stops

	// bit period per rate index
	function automatic logic [`SSDP_DIV_W-1:0] rate_div(input logic [2:0] s);
		case (s)
			3'h0: rate_div = `SSDP_DIV_W'(`SSDP_CLK_HZ / `SSDP_BAUD_0);
			3'h1: rate_div = `SSDP_DIV_W'(`SSDP_CLK_HZ / `SSDP_BAUD_1);
			3'h2: rate_div = `SSDP_DIV_W'(`SSDP_CLK_HZ / `SSDP_BAUD_2);
			3'h3: rate_div = `SSDP_DIV_W'(`SSDP_CLK_HZ / `SSDP_BAUD_3);
			3'h4: rate_div = `SSDP_DIV_W'(`SSDP_CLK_HZ / `SSDP_BAUD_4);
			3'h5: rate_div = `SSDP_DIV_W'(`SSDP_CLK_HZ / `SSDP_BAUD_5);
			3'h6: rate_div = `SSDP_DIV_W'(`SSDP_CLK_HZ / `SSDP_BAUD_6);
			default: rate_div = `SSDP_DIV_W'(`SSDP_CLK_HZ / `SSDP_BAUD_7);
		endcase
	endfunction

	// binary mode overrides the frame settings
	always_comb begin
		div    = bin_q ? `SSDP_DIV_W'(`SSDP_CLK_HZ / `SSDP_BAUD_BIN) : rate_div(baud_q);
		nbits  = bin_q ? `SSDP_BITS_BIN : `SSDP_BITS_ASCII;
		epar   = bin_q ? ssdp_pkg::PAR_ODD : par_q;
		estop2 = bin_q ? 1'b0 : stop2_q;
	end

	// configuration registers, factory defaults at reset
	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			baud_q  <= `SSDP_DEF_BAUD;
			par_q   <= ssdp_pkg::ssdp_par_t'(`SSDP_DEF_PAR);
			stop2_q <= `SSDP_DEF_STOP2;
			fourw_q <= `SSDP_DEF_FOURW;
			rs485_q <= 1'b0;
			bin_q   <= 1'b0;
			addr_q  <= `SSDP_DEF_ADDR;
			short_q <= `SSDP_DEF_SHORT;
			ivl_q   <= `SSDP_DEF_IVL;
		end else if (I_CFG_LOAD) begin
			baud_q  <= I_BAUD_SEL;
			par_q   <= ssdp_pkg::ssdp_par_t'(I_PARITY_SEL);
			stop2_q <= I_TWO_STOP;
			fourw_q <= I_FOUR_WIRE;
			rs485_q <= I_RS485;
			bin_q   <= I_BINARY_MODE;
			addr_q  <= I_NET_ADDR;
			short_q <= I_SHORT_LINE;
			ivl_q   <= I_AUTO_INTERVAL;
		end
	end

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic rxd_m_q, rxd_s_q, cts_m_q, cts_s_q; // first stage feeds second only

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			rxd_m_q <= 1'b1;
			rxd_s_q <= 1'b1;
			cts_m_q <= 1'b0;
			cts_s_q <= 1'b0;
		end else begin
			rxd_m_q <= I_RXD;
			rxd_s_q <= rxd_m_q;
			cts_m_q <= I_CTS;
			cts_s_q <= cts_m_q;
		end
	end

	// ----------------------------------------------------------------
	// receiver
	// ----------------------------------------------------------------
	ssdp_pkg::ssdp_rx_t rx_st_q, rx_st_d;
	logic [`SSDP_DIV_W-1:0] rx_cnt_q, rx_cnt_d; // bit timer
	logic [3:0] rx_idx_q, rx_idx_d;   // data bit index
	logic [7:0] rx_sh_q, rx_sh_d;     // shift register
	logic       rx_pe_q, rx_pe_d;     // parity error
	logic       push;                 // word complete
	logic [9:0] push_w;               // ferr, perr, data
	logic [7:0] rx_byte;              // aligned data
	logic       xoff_q, xoff_d;       // host paused us

	always_comb begin
		rx_st_d  = rx_st_q;
		rx_cnt_d = (rx_cnt_q == '0) ? div - 1'b1 : rx_cnt_q - 1'b1;
		rx_idx_d = rx_idx_q;
		rx_sh_d  = rx_sh_q;
		rx_pe_d  = rx_pe_q;
		push     = 1'b0;
		xoff_d   = xoff_q;
		rx_byte  = bin_q ? rx_sh_q : {1'b0, rx_sh_q[7:1]};
		push_w   = {!rxd_s_q, rx_pe_q, rx_byte};
		unique case (rx_st_q)
			ssdp_pkg::RX_IDLE: begin
				rx_cnt_d = div >> 1;
				if (!rxd_s_q) begin
					rx_st_d = ssdp_pkg::RX_START;
				end
			end
			ssdp_pkg::RX_START: if (rx_cnt_q == '0) begin
				rx_st_d  = rxd_s_q ? ssdp_pkg::RX_IDLE : ssdp_pkg::RX_DATA; // glitch rejected
				rx_idx_d = '0;
				rx_pe_d  = 1'b0;
			end
			ssdp_pkg::RX_DATA: if (rx_cnt_q == '0) begin
				rx_sh_d  = {rxd_s_q, rx_sh_q[7:1]}; // lsb arrives first
				rx_idx_d = rx_idx_q + 4'h1;
				if (rx_idx_d == nbits) begin
					rx_st_d = (epar == ssdp_pkg::PAR_NONE) ? ssdp_pkg::RX_STOP : ssdp_pkg::RX_PAR;
				end
			end
			ssdp_pkg::RX_PAR: if (rx_cnt_q == '0) begin
				unique case (epar)
					ssdp_pkg::PAR_ODD:  rx_pe_d = rxd_s_q != ~^rx_byte;
					ssdp_pkg::PAR_EVEN: rx_pe_d = rxd_s_q != ^rx_byte;
					default:            rx_pe_d = rxd_s_q;
				endcase
				rx_st_d = ssdp_pkg::RX_STOP;
			end
			ssdp_pkg::RX_STOP: if (rx_cnt_q == '0) begin
				rx_st_d = ssdp_pkg::RX_IDLE;
				// outside four-wire and binary modes, in-band flow characters are consumed, not delivered
				if (!fourw_q && !bin_q && rx_byte == `SSDP_XOFF) begin
					xoff_d = 1'b1;
				end else if (!fourw_q && !bin_q && rx_byte == `SSDP_XON) begin
					xoff_d = 1'b0;
				end else begin
					push = 1'b1;
				end
			end
			default: rx_st_d = ssdp_pkg::RX_IDLE;
		endcase
		if (fourw_q) begin
			xoff_d = 1'b0;
		end
	end

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			rx_st_q  <= ssdp_pkg::RX_IDLE;
			rx_cnt_q <= '0;
			rx_idx_q <= '0;
			rx_sh_q  <= '0;
			rx_pe_q  <= 1'b0;
			xoff_q   <= 1'b0;
		end else begin
			rx_st_q  <= rx_st_d;
			rx_cnt_q <= rx_cnt_d;
			rx_idx_q <= rx_idx_d;
			rx_sh_q  <= rx_sh_d;
			rx_pe_q  <= rx_pe_d;
			xoff_q   <= xoff_d;
		end
	end

	// ----------------------------------------------------------------
	// two-entry receive buffer
	// ----------------------------------------------------------------
	logic [9:0] head_q, head_d, tail_q, tail_d;
	logic       hv_q, hv_d, tv_q, tv_d, ovr_d, dtr_d, am_d;

	always_comb begin
		head_d = head_q;
		tail_d = tail_q;
		hv_d   = hv_q;
		tv_d   = tv_q;
		ovr_d  = 1'b0;
		// pop first so a full buffer can take a word in the same cycle
		if (hv_q && I_RX_READY) begin
			head_d = tail_q;
			hv_d   = tv_q;
			tv_d   = 1'b0;
		end
		if (push && !hv_d) begin
			head_d = push_w;
			hv_d   = 1'b1;
		end else if (push && !tv_d) begin
			tail_d = push_w;
			tv_d   = 1'b1;
		end else if (push) begin
			ovr_d = 1'b1; // word dropped
		end
		dtr_d = !fourw_q || !tv_d;
		am_d  = push && bin_q && push_w[4:0] == addr_q;
	end

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			head_q       <= '0;
			tail_q       <= '0;
			hv_q         <= 1'b0;
			tv_q         <= 1'b0;
			O_RX_OVERRUN <= 1'b0;
			O_DTR        <= 1'b1;
			O_ADDR_MATCH <= 1'b0;
		end else begin
			head_q       <= head_d;
			tail_q       <= tail_d;
			hv_q         <= hv_d;
			tv_q         <= tv_d;
			O_RX_OVERRUN <= ovr_d;
			O_DTR        <= dtr_d;
			O_ADDR_MATCH <= am_d;
		end
	end

	// ----------------------------------------------------------------
	// transmitter
	// ----------------------------------------------------------------
	ssdp_pkg::ssdp_tx_t tx_st_q, tx_st_d;
	logic [`SSDP_DIV_W-1:0] tx_cnt_q, tx_cnt_d; // bit timer
	logic [3:0] tx_idx_q, tx_idx_d;
	logic [7:0] tx_sh_q, tx_sh_d;
	logic       tx_pb_q, tx_pb_d;     // parity bit to send
	logic       tx_sl_q, tx_sl_d;     // second stop pending
	logic       txd_d, tx_ok, tx_go;
	logic [7:0] tx_w;

	always_comb begin
		tx_st_d  = tx_st_q;
		tx_cnt_d = (tx_cnt_q == '0) ? div - 1'b1 : tx_cnt_q - 1'b1;
		tx_idx_d = tx_idx_q;
		tx_sh_d  = tx_sh_q;
		tx_pb_d  = tx_pb_q;
		tx_sl_d  = tx_sl_q;
		txd_d    = O_TXD;
		tx_w     = bin_q ? I_TX_DATA : {1'b0, I_TX_DATA[6:0]};
		// start only when the partner lets us and the pair is free
		tx_ok = (!fourw_q || cts_s_q) && (fourw_q || !xoff_q)
			&& !(rs485_q && rx_st_q != ssdp_pkg::RX_IDLE);
		tx_go = (tx_st_q == ssdp_pkg::TX_HOLD) && tx_ok;
		unique case (tx_st_q)
			ssdp_pkg::TX_IDLE: if (I_TX_VALID) begin
				tx_sh_d = tx_w;
				unique case (epar)
					ssdp_pkg::PAR_ODD:  tx_pb_d = ~^tx_w;
					ssdp_pkg::PAR_EVEN: tx_pb_d = ^tx_w;
					default:            tx_pb_d = 1'b0;
				endcase
				tx_st_d = ssdp_pkg::TX_HOLD;
			end
			ssdp_pkg::TX_HOLD: if (tx_ok) begin
				tx_st_d  = ssdp_pkg::TX_START;
				tx_cnt_d = div - 1'b1;
				txd_d    = 1'b0;
			end
			ssdp_pkg::TX_START: if (tx_cnt_q == '0) begin
				txd_d    = tx_sh_q[0];
				tx_sh_d  = tx_sh_q >> 1;
				tx_idx_d = 4'h1;
				tx_st_d  = ssdp_pkg::TX_DATA;
			end
			ssdp_pkg::TX_DATA: if (tx_cnt_q == '0) begin
				if (tx_idx_q == nbits) begin
					tx_sl_d = estop2;
					if (epar == ssdp_pkg::PAR_NONE) begin
						txd_d   = 1'b1;
						tx_st_d = ssdp_pkg::TX_STOP;
					end else begin
						txd_d   = tx_pb_q;
						tx_st_d = ssdp_pkg::TX_PAR;
					end
				end else begin
					txd_d    = tx_sh_q[0];
					tx_sh_d  = tx_sh_q >> 1;
					tx_idx_d = tx_idx_q + 4'h1;
				end
			end
			ssdp_pkg::TX_PAR: if (tx_cnt_q == '0) begin
				txd_d   = 1'b1;
				tx_st_d = ssdp_pkg::TX_STOP;
			end
			ssdp_pkg::TX_STOP: if (tx_cnt_q == '0) begin
				tx_sl_d = 1'b0;
				tx_st_d = tx_sl_q ? ssdp_pkg::TX_STOP : ssdp_pkg::TX_IDLE;
			end
			default: tx_st_d = ssdp_pkg::TX_IDLE;
		endcase
	end

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			tx_st_q    <= ssdp_pkg::TX_IDLE;
			tx_cnt_q   <= '0;
			tx_idx_q   <= '0;
			tx_sh_q    <= '0;
			tx_pb_q    <= 1'b0;
			tx_sl_q    <= 1'b0;
			O_TXD      <= 1'b1;
			O_TXD_OE   <= 1'b1;
			O_TX_READY <= 1'b1;
		end else begin
			tx_st_q    <= tx_st_d;
			tx_cnt_q   <= tx_cnt_d;
			tx_idx_q   <= tx_idx_d;
			tx_sh_q    <= tx_sh_d;
			tx_pb_q    <= tx_pb_d;
			tx_sl_q    <= tx_sl_d;
			O_TXD      <= txd_d;
			O_TXD_OE   <= !rs485_q || tx_st_d > ssdp_pkg::TX_HOLD;
			O_TX_READY <= tx_st_d == ssdp_pkg::TX_IDLE;
		end
	end

	// ----------------------------------------------------------------
	// auto output, format, control outputs
	// ----------------------------------------------------------------
	logic [7:0] upd_q, upd_d;
	logic       trig_d;

	always_comb begin
		upd_d  = upd_q;
		trig_d = 1'b0;
		if (I_DISP_UPDATE) begin
			upd_d = upd_q + 8'h01;
			if (upd_d >= ivl_q) begin
				upd_d  = 8'h00;
				trig_d = 1'b1;
			end
		end
	end

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			upd_q        <= 8'h00;
			O_AUTO_TRIG  <= 1'b0;
			O_LINE_LEN   <= `SSDP_LEN_LONG;
			O_RX_DATA    <= 8'h00;
			O_RX_PERR    <= 1'b0;
			O_RX_FERR    <= 1'b0;
			O_RX_VALID   <= 1'b0;
			O_CW_SET     <= 1'b0;
			O_CW_EQUAL   <= 1'b0;
			O_CW_LIGHTER <= 1'b0;
			O_CW_HEAVIER <= 1'b0;
		end else begin
			upd_q        <= upd_d;
			O_AUTO_TRIG  <= trig_d;
			O_LINE_LEN   <= short_q ? `SSDP_LEN_SHORT : `SSDP_LEN_LONG;
			O_RX_DATA    <= head_d[7:0];
			O_RX_PERR    <= head_d[8];
			O_RX_FERR    <= head_d[9];
			O_RX_VALID   <= hv_d;
			O_CW_SET     <= I_CW_SET;
			O_CW_EQUAL   <= I_CW_EQUAL;
			O_CW_LIGHTER <= I_CW_LIGHTER;
			O_CW_HEAVIER <= I_CW_HEAVIER;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	sequence s_go;
		tx_go;
	endsequence

	chk_cts_gate: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		s_go |-> (!fourw_q || cts_s_q)) else $error("start without clear to send");
	chk_xoff_gate: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		s_go |-> (fourw_q || !xoff_q)) else $error("start while paused");
	chk_half_duplex: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		s_go |-> !(rs485_q && rx_st_q != ssdp_pkg::RX_IDLE)) else $error("send while receiving");
	chk_start_low: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		s_go |=> !O_TXD [*2]) else $error("start bit not low");
	chk_idle_mark: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		tx_st_q == ssdp_pkg::TX_IDLE |-> O_TXD) else $error("idle line not mark");
	chk_bin_rate: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		bin_q |-> (div == `SSDP_DIV_W'(`SSDP_CLK_HZ / `SSDP_BAUD_BIN) && nbits == `SSDP_BITS_BIN
		&& !estop2)) else $error("binary framing not fixed");
	chk_line_len: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		##1 O_LINE_LEN == ($past(short_q) ? `SSDP_LEN_SHORT : `SSDP_LEN_LONG))
		else $error("line length wrong");
	chk_cw_follow: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		##1 {O_CW_SET, O_CW_EQUAL, O_CW_LIGHTER, O_CW_HEAVIER}
		== $past({I_CW_SET, I_CW_EQUAL, I_CW_LIGHTER, I_CW_HEAVIER}))
		else $error("checkweigh output lags");
	chk_addr_mode: assert property (@(posedge I_CLK) disable iff (!I_NRST)
		!bin_q |=> !O_ADDR_MATCH) else $error("address used outside binary mode");

endmodule // ssdp_top

// [core/ssdp_params.svh]
// Purpose: timing counts, defaults and codes of the serial data port
// Assumes: 40 MHz system clock
// Notes:   definitions only
`ifndef SSDP_PARAMS_SVH
`define SSDP_PARAMS_SVH
// ----------------------------------------------------------------
// clock and bit rates
// ----------------------------------------------------------------
`define SSDP_CLK_HZ     40000000
`define SSDP_BAUD_0     150
`define SSDP_BAUD_1     300
`define SSDP_BAUD_2     600
`define SSDP_BAUD_3     1200
`define SSDP_BAUD_4     2400
`define SSDP_BAUD_5     4800
`define SSDP_BAUD_6     9600
`define SSDP_BAUD_7     19200
`define SSDP_BAUD_BIN   9600
`define SSDP_DIV_W      19
// ----------------------------------------------------------------
// factory defaults
// ----------------------------------------------------------------
`define SSDP_DEF_BAUD   3'h3
`define SSDP_DEF_PAR    2'h1
`define SSDP_DEF_STOP2  1'b0
`define SSDP_DEF_FOURW  1'b1
`define SSDP_DEF_ADDR   5'h00
`define SSDP_DEF_SHORT  1'b0
`define SSDP_DEF_IVL    8'h01
// ----------------------------------------------------------------
// frame and format codes
// ----------------------------------------------------------------
`define SSDP_BITS_ASCII 4'h7
`define SSDP_BITS_BIN   4'h8
`define SSDP_LEN_LONG   5'h16
`define SSDP_LEN_SHORT  5'h10
`define SSDP_XON        8'h11
`define SSDP_XOFF       8'h13
`endif

// [core/ssdp_pkg.sv]
// Purpose: types of the serial data port
// Assumes: nothing
// Notes:   states and parity modes
package ssdp_pkg;
	// parity choice
	typedef enum logic [1:0] {
		PAR_SPACE = 2'h0,
		PAR_ODD   = 2'h1,
		PAR_EVEN  = 2'h2,
		PAR_NONE  = 2'h3
	} ssdp_par_t;
	// transmitter states
	typedef enum logic [2:0] {
		TX_IDLE  = 3'h0,
		TX_HOLD  = 3'h1,
		TX_START = 3'h2,
		TX_DATA  = 3'h3,
		TX_PAR   = 3'h4,
		TX_STOP  = 3'h5
	} ssdp_tx_t;
	// receiver states
	typedef enum logic [2:0] {
		RX_IDLE  = 3'h0,
		RX_START = 3'h1,
		RX_DATA  = 3'h2,
		RX_PAR   = 3'h3,
		RX_STOP  = 3'h4
	} ssdp_rx_t;
endpackage

// [testbench/ssdp_host.sv]
// Purpose: host side model of the serial link of the data port
// Assumes: both ends run at one bit time of DIV clocks
// Notes:   the testbench calls the tasks; CTS is owned here
`timescale 1ns/10ps
module ssdp_host #(
	parameter int DIV = 2083 // clocks per bit
) (
	// clock
	input  wire logic I_CLK,
	// serial lines
	input  wire logic I_TXD,
	output logic      O_RXD,
	output logic      O_CTS
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	int low_cnt; // cycles with the device output at space

	// line idles at mark, host ready to take
	initial begin
		O_RXD   = 1'b1;
		O_CTS   = 1'b1;
		low_cnt = 0;
	end

	// count space cycles on the device output
	always @(posedge I_CLK) begin
		if (I_TXD === 1'b0) begin
			low_cnt <= low_cnt + 1;
		end
	end

	// change the clear-to-send line just after an edge
	task automatic set_cts(input logic v);
		@(posedge I_CLK);
		O_CTS <= v;
	endtask

	// one frame: start, seven data lsb first, parity, one stop
	task automatic send(input logic [7:0] bits);
		@(posedge I_CLK);
		O_RXD <= 1'b0;
		repeat (DIV) @(posedge I_CLK);
		for (int i = 0; i < 8; i++) begin
			O_RXD <= bits[i];
			repeat (DIV) @(posedge I_CLK);
		end
		O_RXD <= 1'b1;
		repeat (DIV) @(posedge I_CLK);
	endtask

	// capture one frame: got = {stop, parity, data}
	task automatic recv(output logic [8:0] got);
		int n;
		n = 0;
		while (I_TXD !== 1'b0 && n < 200000) begin
			@(posedge I_CLK);
			n++;
		end
		repeat (DIV / 2) @(posedge I_CLK);
		for (int i = 0; i < 9; i++) begin
			repeat (DIV) @(posedge I_CLK);
			got[i] = I_TXD;
		end
	endtask
endmodule // ssdp_host

// [testbench/testbench.sv]
// Purpose: self-checking bench of the serial data port
// Assumes: link at 19200 baud, 40 MHz clock
// Notes:   receive words are taken late to fill the buffer
`timescale 1ns/10ps
module testbench;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic       clk;         // system clock
	logic       nrst;        // reset, active low
	logic       cfg_load;    // config strobe
	logic [2:0] baud_sel;    // rate index
	logic [1:0] par_sel;     // parity choice
	logic       short_line;  // 16 char lines
	logic [7:0] ivl;         // auto interval
	logic [7:0] tx_data;     // word offered
	logic       tx_valid;    // offer strobe
	logic       tx_ready;    // transmitter idle
	logic [7:0] rx_data;     // head word
	logic       rx_perr;     // parity error
	logic       rx_ferr;     // framing error
	logic       rx_valid;    // head valid
	logic       rx_ready;    // take head
	logic       txd;         // serial out
	logic       rxd;         // serial in
	logic       cts;         // clear to send
	logic       dtr;         // room to receive
	logic       txd_oe;      // driver enable
	logic       rx_ovr;      // word lost pulse
	logic       addr_match;  // address hit pulse
	logic       disp;        // display update
	logic       auto_trig;   // auto record due
	logic [4:0] line_len;    // line length
	logic [3:0] cw_i;        // checkweigh results
	logic [3:0] cw_o;        // checkweigh outputs
	logic [8:0] got;         // captured frame
	int         num_errors;  // mismatches
	int         comparisons; // compares made
	int         trig_cnt;    // auto pulses seen
	int         base;        // pulse count snapshot
	int         flag_cnt;    // overrun or address pulses seen

	// ----------------------------------------------------------------
	// instances
	// ----------------------------------------------------------------
	ssdp_top ssdp_top_i (
		.I_CLK(clk), .I_NRST(nrst), .I_CFG_LOAD(cfg_load), .I_BAUD_SEL(baud_sel),
		.I_PARITY_SEL(par_sel), .I_TWO_STOP(1'b0), .I_FOUR_WIRE(1'b1), .I_RS485(1'b0),
		.I_BINARY_MODE(1'b0), .I_NET_ADDR(5'h00), .I_SHORT_LINE(short_line),
		.I_AUTO_INTERVAL(ivl), .I_TX_DATA(tx_data), .I_TX_VALID(tx_valid),
		.O_TX_READY(tx_ready), .O_RX_DATA(rx_data), .O_RX_PERR(rx_perr),
		.O_RX_FERR(rx_ferr), .O_RX_VALID(rx_valid), .I_RX_READY(rx_ready),
		.O_RX_OVERRUN(rx_ovr), .O_ADDR_MATCH(addr_match), .I_RXD(rxd), .O_TXD(txd),
		.O_TXD_OE(txd_oe),
		.I_CTS(cts), .O_DTR(dtr), .I_DISP_UPDATE(disp), .O_AUTO_TRIG(auto_trig),
		.O_LINE_LEN(line_len), .I_CW_SET(cw_i[3]), .I_CW_EQUAL(cw_i[2]),
		.I_CW_LIGHTER(cw_i[1]), .I_CW_HEAVIER(cw_i[0]), .O_CW_SET(cw_o[3]),
		.O_CW_EQUAL(cw_o[2]), .O_CW_LIGHTER(cw_o[1]), .O_CW_HEAVIER(cw_o[0])
	);
	ssdp_host #(.DIV(2083)) ssdp_host_i (.I_CLK(clk), .I_TXD(txd), .O_RXD(rxd), .O_CTS(cts));

	// ----------------------------------------------------------------
	// clock, counters, tasks
	// ----------------------------------------------------------------
	// 40 MHz clock
	always #12.5 clk = ~clk;

	// count auto record pulses
	always @(posedge clk) begin
		if (auto_trig === 1'b1) begin
			trig_cnt <= trig_cnt + 1;
		end
	end

	// count overrun or address pulses once out of reset
	always @(posedge clk) begin
		if (nrst === 1'b1 && (rx_ovr !== 1'b0 || addr_match !== 1'b0)) begin
			flag_cnt <= flag_cnt + 1;
		end
	end

	// compare one value
	task automatic check(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// print counts and verdict, end the run
	task automatic finish_test();
		$display("errors=%0d comparisons=%0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// load rate, parity, line format and interval
	task automatic load_cfg(input logic [1:0] p, input logic s, input logic [7:0] v);
		@(posedge clk);
		baud_sel   <= 3'h7;
		par_sel    <= p;
		short_line <= s;
		ivl        <= v;
		cfg_load   <= 1'b1;
		@(posedge clk);
		cfg_load   <= 1'b0;
	endtask

	// display update pulses, spaced apart
	task automatic disp_pulses(input int n);
		repeat (n) begin
			@(posedge clk);
			disp <= 1'b1;
			@(posedge clk);
			disp <= 1'b0;
			repeat (3) @(posedge clk);
		end
		repeat (2) @(posedge clk);
	endtask

	// offer one word, hold until the transmitter takes it
	task automatic tx_put(input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		tx_data  <= d;
		tx_valid <= 1'b1;
		@(posedge clk);
		while (tx_ready !== 1'b1 && n < 100000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 100000) begin
			num_errors++;
		end
		tx_valid <= 1'b0;
	endtask

	// wait for the head word, compare {perr, ferr, data}, take it
	task automatic rx_take(input logic [9:0] e);
		int n;
		n = 0;
		while (rx_valid !== 1'b1 && n < 10000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 10000) begin
			num_errors++;
		end
		check({rx_perr, rx_ferr, rx_data}, e);
		@(posedge clk);
		rx_ready <= 1'b1;
		@(posedge clk);
		rx_ready <= 1'b0;
		@(posedge clk);
	endtask

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0; nrst = 1'b0; cfg_load = 1'b0; baud_sel = 3'h3; par_sel = 2'h1;
		short_line = 1'b0; ivl = 8'h01; tx_data = 8'h00; tx_valid = 1'b0;
		rx_ready = 1'b0; disp = 1'b0; cw_i = 4'h0; num_errors = 0; comparisons = 0;
		trig_cnt = 0;
		flag_cnt = 0;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		check(line_len, 16'h0016);
		check({txd, dtr, tx_ready}, 16'h0007);
		check({txd_oe, rx_ovr, addr_match}, 16'h0004);
		// each checkweigh output follows its result
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			cw_i <= 4'h1 << k;
			repeat (2) @(posedge clk);
			check(cw_o, 16'h0001 << k);
		end
		// one record per update by default, then every third
		base = trig_cnt;
		disp_pulses(2);
		check(trig_cnt - base, 16'h0002);
		load_cfg(2'h2, 1'b1, 8'h03);
		base = trig_cnt;
		disp_pulses(6);
		check(trig_cnt - base, 16'h0002);
		check(line_len, 16'h0010);
		// transmit: top bit dropped, lsb first, even parity
		tx_put(8'hD5);
		ssdp_host_i.recv(got);
		check(got, {1'b1, ^7'h55, 7'h55});
		// clear-to-send withdrawn: word held while two words arrive
		ssdp_host_i.set_cts(1'b0);
		repeat (4) @(posedge clk);
		base = ssdp_host_i.low_cnt;
		tx_put(8'h23);
		ssdp_host_i.send({^7'h41, 7'h41});
		ssdp_host_i.send({1'b1, 7'h30});
		repeat (4) @(posedge clk);
		check(ssdp_host_i.low_cnt - base, 16'h0000);
		check({dtr, tx_ready}, 16'h0000);
		rx_take(10'h041);
		rx_take(10'h230);
		// clear again: held word goes out
		ssdp_host_i.set_cts(1'b1);
		ssdp_host_i.recv(got);
		check(got, {1'b1, ^7'h23, 7'h23});
		check(flag_cnt, 16'h0000);
		finish_test();
	end

	// watchdog
	initial begin
		repeat (100000) @(posedge clk);
		num_errors++;
		finish_test();
	end
endmodule // testbench
